//--- hw/xrc_pkg.sv
/*
 * Constants of the lane control read block: register map, fields,
 * reset values, clock source codes and cycle counts.
 * Assumes one 10 MHz system clock and an AXI4-Lite master with 32-bit data.
 */
// Behaviour
// - Busy high during fetch, low after
// - Data valid flags returned control values
// - Core clocks write transmit, read receive FIFO
// - Fabric core clock overrides lane output clock
// - Otherwise lane output clock writes transmit FIFO
// - Shared mode uses lane 0 output clock
// - Receive: shared, own transmit, own receive
// - Transmit: shared or own lane clock
// - Four lanes give two-bit lane select
package xrc_pkg;

  localparam int LANES     = 4;
  localparam int LANE_W    = 2;
  localparam int ANA_W     = 8;
  localparam int ADDR_W    = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_RDATA  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CLKCFG = 4'hC;

  // Control register fields
  localparam int CTRL_LANE_LSB = 0;
  localparam int CTRL_DIR_LSB  = 4;
  localparam int CTRL_START    = 8;
  localparam int CTRL_DRST     = 9;

  // Status register fields
  localparam int STAT_BUSY  = 0;
  localparam int STAT_VALID = 1;

  // Clock configuration fields
  localparam int CCFG_TX_SHARED = 0;
  localparam int CCFG_FABRIC    = 1;
  localparam int CCFG_RX_LSB    = 2;

  // Reset values
  localparam logic [LANE_W-1:0] RST_LANE   = 2'h0;
  localparam logic [1:0]        RST_DIR    = 2'h2;
  localparam logic [3:0]        RST_CLKCFG = 4'h0;

  // Direction codes
  localparam logic [1:0] DIR_RX   = 2'h1;
  localparam logic [1:0] DIR_TX   = 2'h2;
  localparam logic [1:0] DIR_BOTH = 2'h3;

  // Transmit FIFO write clock sources
  localparam logic [1:0] TXSEL_OWN    = 2'h0;
  localparam logic [1:0] TXSEL_LANE0  = 2'h1;
  localparam logic [1:0] TXSEL_FABRIC = 2'h2;

  // Receive FIFO read clock sources
  localparam logic [1:0] RXSEL_SHARED_TX = 2'h0;
  localparam logic [1:0] RXSEL_OWN_TX    = 2'h1;
  localparam logic [1:0] RXSEL_OWN_RX    = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Cycle counts
  localparam int FETCH_CYCLES  = 4;
  localparam int DRST_CYCLES   = 2;
  localparam int CNT_W         = 3;

endpackage

//--- hw/xrc_rd_if.sv
/*
 * Link between the register front end and the read engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface xrc_rd_if;
  logic                                    start;
  logic [xrc_pkg::LANE_W-1:0]              lane;
  logic [1:0]                              dir;
  logic                                    busy;
  logic                                    valid;
  logic [2*xrc_pkg::ANA_W-1:0]             data;

  modport ctrl   (output start, output lane, output dir, input busy, input valid, input data);
  modport engine (input start, input lane, input dir, output busy, output valid, output data);
endinterface

//--- hw/xrc_read_engine.sv
/*
 * Read engine: fetches one lane's analog controls on a start pulse.
 * Assumes the lane control inputs are on clk_sys and stable while fetched.
 */
`timescale 1ns/1ps
module xrc_read_engine (
  // Clock and reset
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst,
  // Request side
  xrc_rd_if.engine                                     rd,
  // Analog section values, one byte per lane
  input  wire logic [xrc_pkg::LANES*xrc_pkg::ANA_W-1:0] lane_tx_ctrl,
  input  wire logic [xrc_pkg::LANES*xrc_pkg::ANA_W-1:0] lane_rx_ctrl
);

  typedef enum logic {XRC_IDLE, XRC_FETCH} xrc_state_t;

  xrc_state_t                     state_q, state_d;
  logic [xrc_pkg::CNT_W-1:0]      cnt_q, cnt_d;
  logic [xrc_pkg::LANE_W-1:0]     lane_q, lane_d;
  logic [1:0]                     dir_q, dir_d;
  logic                           busy_q, busy_d;
  logic                           valid_q, valid_d;
  logic [2*xrc_pkg::ANA_W-1:0]    data_q, data_d;
  logic [xrc_pkg::ANA_W-1:0]      tx_sel, rx_sel;

  assign tx_sel = lane_tx_ctrl[lane_q*xrc_pkg::ANA_W +: xrc_pkg::ANA_W];
  assign rx_sel = lane_rx_ctrl[lane_q*xrc_pkg::ANA_W +: xrc_pkg::ANA_W];

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    lane_d  = lane_q;
    dir_d   = dir_q;
    busy_d  = busy_q;
    valid_d = valid_q;
    data_d  = data_q;
    case (state_q)
      XRC_IDLE: begin
        // Strobe only counts here, so a pulse during a fetch is dropped
        if (rd.start) begin
          lane_d  = rd.lane;
          dir_d   = rd.dir;
          valid_d = 1'b0;
          busy_d  = 1'b1;
          cnt_d   = xrc_pkg::CNT_W'(xrc_pkg::FETCH_CYCLES - 1);
          state_d = XRC_FETCH;
        end
      end
      XRC_FETCH: begin
        if (cnt_q == '0) begin
          case (dir_q)
            xrc_pkg::DIR_TX:   data_d = {{xrc_pkg::ANA_W{1'b0}}, tx_sel};
            xrc_pkg::DIR_RX:   data_d = {rx_sel, {xrc_pkg::ANA_W{1'b0}}};
            xrc_pkg::DIR_BOTH: data_d = {rx_sel, tx_sel};
            default:           data_d = '0;
          endcase
          busy_d  = 1'b0;
          valid_d = 1'b1;
          state_d = XRC_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: state_d = XRC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= XRC_IDLE;
      cnt_q   <= '0;
      lane_q  <= xrc_pkg::RST_LANE;
      dir_q   <= xrc_pkg::RST_DIR;
      busy_q  <= 1'b0;
      valid_q <= 1'b0;
      data_q  <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      lane_q  <= lane_d;
      dir_q   <= dir_d;
      busy_q  <= busy_d;
      valid_q <= valid_d;
      data_q  <= data_d;
    end
  end

  assign rd.busy  = busy_q;
  assign rd.valid = valid_q;
  assign rd.data  = data_q;

endmodule

//--- hw/xrc_top.sv
/*
 * Lane control read block with core clock source selection,
 * reached over AXI4-Lite.
 * Assumes lane control values arrive on clk_sys; clock selects drive
 * clock muxes outside this block.
 */
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module xrc_top (
  // Clock and reset
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst,
  // AXI4-Lite write address
  input  wire logic                                    s_axi_awvalid,
  output logic                                         s_axi_awready,
  input  wire logic [xrc_pkg::ADDR_W-1:0]              s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                                    s_axi_wvalid,
  output logic                                         s_axi_wready,
  input  wire logic [31:0]                             s_axi_wdata,
  input  wire logic [3:0]                              s_axi_wstrb,
  // AXI4-Lite write response
  output logic                                         s_axi_bvalid,
  input  wire logic                                    s_axi_bready,
  output logic [1:0]                                   s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                                    s_axi_arvalid,
  output logic                                         s_axi_arready,
  input  wire logic [xrc_pkg::ADDR_W-1:0]              s_axi_araddr,
  // AXI4-Lite read data
  output logic                                         s_axi_rvalid,
  input  wire logic                                    s_axi_rready,
  output logic [31:0]                                  s_axi_rdata,
  output logic [1:0]                                   s_axi_rresp,
  // Analog section values
  input  wire logic [xrc_pkg::LANES*xrc_pkg::ANA_W-1:0] lane_tx_ctrl,
  input  wire logic [xrc_pkg::LANES*xrc_pkg::ANA_W-1:0] lane_rx_ctrl,
  // Status and clocking outputs
  output logic                                         busy,
  output logic                                         data_valid,
  output logic [2*xrc_pkg::LANES-1:0]                  tx_wr_clk_sel,
  output logic [2*xrc_pkg::LANES-1:0]                  rx_rd_clk_sel,
  output logic                                         digital_rst
);

  xrc_rd_if rd ();

  xrc_read_engine u_engine (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .rd           (rd),
    .lane_tx_ctrl (lane_tx_ctrl),
    .lane_rx_ctrl (lane_rx_ctrl)
  );

  // Bus state
  logic                          awready_q, awready_d;
  logic                          wready_q, wready_d;
  logic                          aw_got_q, aw_got_d;
  logic                          w_got_q, w_got_d;
  logic [xrc_pkg::ADDR_W-1:0]    waddr_q, waddr_d;
  logic [31:0]                   wdata_q, wdata_d;
  logic [3:0]                    wstrb_q, wstrb_d;
  logic                          bvalid_q, bvalid_d;
  logic [1:0]                    bresp_q, bresp_d;
  logic                          arready_q, arready_d;
  logic                          rvalid_q, rvalid_d;
  logic [31:0]                   rdata_q, rdata_d;
  logic [1:0]                    rresp_q, rresp_d;
  // Register state
  logic [xrc_pkg::LANE_W-1:0]    lane_q, lane_d;
  logic [1:0]                    dir_q, dir_d;
  logic [3:0]                    clkcfg_q, clkcfg_d;
  logic                          start_q, start_d;
  logic [xrc_pkg::CNT_W-1:0]     drst_cnt_q, drst_cnt_d;
  logic                          drst_q, drst_d;
  logic [2*xrc_pkg::LANES-1:0]   txsel_q, txsel_d;
  logic [2*xrc_pkg::LANES-1:0]   rxsel_q, rxsel_d;
  logic [31:0]                   wmask;
  logic [31:0]                   ctrl_new;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{wstrb_q[i]}};
    end
  end

  assign ctrl_new = wdata_q & wmask;

  // Write channels
  always_comb begin
    aw_got_d   = aw_got_q | (s_axi_awvalid & awready_q);
    w_got_d    = w_got_q | (s_axi_wvalid & wready_q);
    waddr_d    = (s_axi_awvalid & awready_q) ? s_axi_awaddr : waddr_q;
    wdata_d    = (s_axi_wvalid & wready_q) ? s_axi_wdata : wdata_q;
    wstrb_d    = (s_axi_wvalid & wready_q) ? s_axi_wstrb : wstrb_q;
    bvalid_d   = bvalid_q & ~s_axi_bready;
    bresp_d    = bresp_q;
    lane_d     = lane_q;
    dir_d      = dir_q;
    clkcfg_d   = clkcfg_q;
    start_d    = 1'b0;
    drst_cnt_d = (drst_cnt_q != '0) ? drst_cnt_q - 1'b1 : drst_cnt_q;
    // Address and data may land in either order; both are needed to commit
    if (aw_got_q && w_got_q && !bvalid_q) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = xrc_pkg::RESP_OKAY;
      if (waddr_q == xrc_pkg::OFS_CTRL) begin
        if (wstrb_q[0]) begin
          lane_d = ctrl_new[xrc_pkg::CTRL_LANE_LSB +: xrc_pkg::LANE_W];
          dir_d  = ctrl_new[xrc_pkg::CTRL_DIR_LSB +: 2];
        end
        // One-cycle strobe; engine drops it if busy
        start_d = ctrl_new[xrc_pkg::CTRL_START];
        if (ctrl_new[xrc_pkg::CTRL_DRST]) begin
          drst_cnt_d = xrc_pkg::CNT_W'(xrc_pkg::DRST_CYCLES);
        end
      end else if (waddr_q == xrc_pkg::OFS_CLKCFG) begin
        if (wstrb_q[0]) begin
          clkcfg_d = ctrl_new[3:0];
        end
      end else if (waddr_q == xrc_pkg::OFS_STATUS || waddr_q == xrc_pkg::OFS_RDATA) begin
        bresp_d = xrc_pkg::RESP_OKAY;
      end else begin
        bresp_d = xrc_pkg::RESP_DECERR;
      end
    end
    awready_d = ~aw_got_d & ~bvalid_d;
    wready_d  = ~w_got_d & ~bvalid_d;
    drst_d    = (drst_cnt_d != '0);
  end

  // Read channel
  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    // Ready comes up after reset and whenever no answer is pending
    if (!arready_q && !rvalid_q) begin
      arready_d = 1'b1;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = xrc_pkg::RESP_OKAY;
      rdata_d   = '0;
      if (s_axi_araddr == xrc_pkg::OFS_CTRL) begin
        rdata_d[xrc_pkg::CTRL_LANE_LSB +: xrc_pkg::LANE_W] = lane_q;
        rdata_d[xrc_pkg::CTRL_DIR_LSB +: 2]                = dir_q;
        rdata_d[xrc_pkg::CTRL_DRST]                        = drst_q;
      end else if (s_axi_araddr == xrc_pkg::OFS_STATUS) begin
        rdata_d[xrc_pkg::STAT_BUSY]  = rd.busy;
        rdata_d[xrc_pkg::STAT_VALID] = rd.valid;
      end else if (s_axi_araddr == xrc_pkg::OFS_RDATA) begin
        rdata_d[2*xrc_pkg::ANA_W-1:0] = rd.data;
      end else if (s_axi_araddr == xrc_pkg::OFS_CLKCFG) begin
        rdata_d[3:0] = clkcfg_q;
      end else begin
        rresp_d = xrc_pkg::RESP_DECERR;
      end
    end
  end

  // Core clock source per lane
  for (genvar g = 0; g < xrc_pkg::LANES; g++) begin : g_lane
    always_comb begin
      // Fabric clock wins over both lane output clock choices
      if (clkcfg_q[xrc_pkg::CCFG_FABRIC]) begin
        txsel_d[2*g +: 2] = xrc_pkg::TXSEL_FABRIC;
      end else if (clkcfg_q[xrc_pkg::CCFG_TX_SHARED] && g != 0) begin
        txsel_d[2*g +: 2] = xrc_pkg::TXSEL_LANE0;
      end else begin
        txsel_d[2*g +: 2] = xrc_pkg::TXSEL_OWN;
      end
      // Code 3 falls back to the lane's own receive clock
      case (clkcfg_q[xrc_pkg::CCFG_RX_LSB +: 2])
        2'h0:    rxsel_d[2*g +: 2] = xrc_pkg::RXSEL_SHARED_TX;
        2'h1:    rxsel_d[2*g +: 2] = xrc_pkg::RXSEL_OWN_TX;
        default: rxsel_d[2*g +: 2] = xrc_pkg::RXSEL_OWN_RX;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      aw_got_q   <= 1'b0;
      w_got_q    <= 1'b0;
      waddr_q    <= '0;
      wdata_q    <= '0;
      wstrb_q    <= '0;
      bvalid_q   <= 1'b0;
      bresp_q    <= xrc_pkg::RESP_OKAY;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= '0;
      rresp_q    <= xrc_pkg::RESP_OKAY;
      lane_q     <= xrc_pkg::RST_LANE;
      dir_q      <= xrc_pkg::RST_DIR;
      clkcfg_q   <= xrc_pkg::RST_CLKCFG;
      start_q    <= 1'b0;
      drst_cnt_q <= '0;
      drst_q     <= 1'b0;
      txsel_q    <= '0;
      rxsel_q    <= '0;
    end else begin
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      aw_got_q   <= aw_got_d;
      w_got_q    <= w_got_d;
      waddr_q    <= waddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      lane_q     <= lane_d;
      dir_q      <= dir_d;
      clkcfg_q   <= clkcfg_d;
      start_q    <= start_d;
      drst_cnt_q <= drst_cnt_d;
      drst_q     <= drst_d;
      txsel_q    <= txsel_d;
      rxsel_q    <= rxsel_d;
    end
  end

  assign rd.start = start_q;
  assign rd.lane  = lane_q;
  assign rd.dir   = dir_q;

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign busy          = rd.busy;
  assign data_valid    = rd.valid;
  assign tx_wr_clk_sel = txsel_q;
  assign rx_rd_clk_sel = rxsel_q;
  assign digital_rst   = drst_q;

endmodule

//--- tb/xrc_props.sv
/*
 * Checker on the top ports: fetch timing, valid flag, reset stretch,
 * bus answers and clock source selects.
 * Assumes one clock domain and an active-high asynchronous reset.
 */
`timescale 1ns/1ps
module xrc_props (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // Status and clocking
  input wire logic       busy,
  input wire logic       data_valid,
  input wire logic [7:0] tx_wr_clk_sel,
  input wire logic [7:0] rx_rd_clk_sel,
  input wire logic       digital_rst
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_fetch;
    !data_valid && busy [*4] ##1 !busy;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  AST_FETCH: assert property ($rose(busy) |-> s_fetch) else $error("busy length or valid wrong");
  AST_VALID_SET: assert property ($fell(busy) |-> data_valid) else $error("valid missing at end");
  AST_VALID_HOLD: assert property ($fell(data_valid) |-> $rose(busy)) else $error("valid lost early");
  AST_DRST: assert property ($rose(digital_rst) |-> digital_rst ##1 digital_rst ##1 !digital_rst) else $error("reset width");
  AST_WR_ANS: assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("no write response");
  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
  AST_TX_SEL: assert property (tx_wr_clk_sel[1:0] != 2'h1 && tx_wr_clk_sel[3:2] == tx_wr_clk_sel[5:4]
    && tx_wr_clk_sel[5:4] == tx_wr_clk_sel[7:6]) else $error("tx select mix");
  AST_RX_SEL: assert property (rx_rd_clk_sel == {4{rx_rd_clk_sel[1:0]}}
    && rx_rd_clk_sel[1:0] != 2'h3) else $error("rx select mix");
endmodule

bind xrc_top xrc_props u_props (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .busy, .data_valid, .tx_wr_clk_sel,
  .rx_rd_clk_sel, .digital_rst);

//--- tb/xrc_lane_model.sv
/*
 * Analog lane section model: one control byte per lane and direction.
 * Assumes the bench asks for new values only while no fetch runs.
 */
`timescale 1ns/1ps
module xrc_lane_model (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Control
  input wire logic        busy,
  input wire logic        shuffle,
  // Lane values
  output logic     [31:0] lane_tx_ctrl,
  output logic     [31:0] lane_rx_ctrl
);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lane_tx_ctrl <= 32'h0;
      lane_rx_ctrl <= 32'h0;
    end else if (shuffle && !busy) begin // Frozen during a fetch
      lane_tx_ctrl <= $urandom;
      lane_rx_ctrl <= $urandom;
    end
  end
endmodule

//--- tb/xrc_top_tb.sv
/*
 * Self-checking bench of the lane control read block over AXI4-Lite.
 * Assumes the design package and the lane model are compiled first.
 */
`timescale 1ns/1ps
module xrc_top_tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, shuffle = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lane_tx_ctrl, lane_rx_ctrl;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        busy, data_valid, digital_rst;
  logic [7:0]  tx_wr_clk_sel, rx_rd_clk_sel;
  logic [31:0] d;
  logic [1:0]  r;
  int          errors = 0, checks = 0, cycles = 0, n, drst_n = 0;

  always #50 clk_sys = ~clk_sys;

  xrc_top dut (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .lane_tx_ctrl, .lane_rx_ctrl,
    .busy, .data_valid, .tx_wr_clk_sel, .rx_rd_clk_sel, .digital_rst);
  xrc_lane_model u_lanes (.clk_sys, .rst, .busy, .shuffle, .lane_tx_ctrl, .lane_rx_ctrl);

  task report_and_stop;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin // Hang guard
      errors++;
      report_and_stop;
    end
  end

  // Counts every cycle the digital reset stands, whenever it is raised
  always @(posedge clk_sys) begin
    if (digital_rst === 1'b1) drst_n++;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task axi_wr(input logic [3:0] a, input logic [31:0] wd, output logic [1:0] resp);
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= wd;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task axi_rd(input logic [3:0] a, output logic [31:0] rd, output logic [1:0] resp);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [31:0] exp_rd(input logic [1:0] ln, input logic [1:0] dir);
    exp_rd = {16'h0, dir[0] ? lane_rx_ctrl[8*ln+:8] : 8'h0, dir[1] ? lane_tx_ctrl[8*ln+:8] : 8'h0};
  endfunction

  task do_read(input logic [1:0] ln, input logic [1:0] dir);
    @(posedge clk_sys);
    shuffle <= 1'b1;
    @(posedge clk_sys);
    shuffle <= 1'b0;
    axi_wr(xrc_pkg::OFS_CTRL, {23'h0, 1'b1, 2'h0, dir, 2'h0, ln}, r);
    n = 0;
    while (busy !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, busy}, 32'h1, "busy not raised");
    chk({31'h0, data_valid}, 32'h0, "valid not cleared");
    n = 0;
    do begin
      axi_rd(xrc_pkg::OFS_STATUS, d, r);
      n++;
    end while (d[0] !== 1'b0 && n < 20);
    chk(d, 32'h2, "status after fetch");
    chk({31'h0, data_valid}, 32'h1, "valid port");
    axi_rd(xrc_pkg::OFS_RDATA, d, r);
    chk(d, exp_rd(ln, dir), "read data");
  endtask

  initial begin
    void'($urandom(9));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    axi_rd(xrc_pkg::OFS_CTRL, d, r);
    chk(d, 32'h20, "ctrl reset");
    axi_rd(xrc_pkg::OFS_CLKCFG, d, r);
    chk(d, 32'h0, "clkcfg reset");
    axi_wr(xrc_pkg::OFS_STATUS, 32'h3, r);
    chk({30'h0, r}, {30'h0, xrc_pkg::RESP_OKAY}, "status write resp");
    axi_rd(xrc_pkg::OFS_STATUS, d, r);
    chk(d, 32'h0, "status unchanged");
    axi_wr(4'h2, 32'h1, r);
    chk({30'h0, r}, {30'h0, xrc_pkg::RESP_DECERR}, "unmapped write");
    axi_rd(4'h6, d, r);
    chk({d[29:0], r}, {30'h0, xrc_pkg::RESP_DECERR}, "unmapped read");
    for (int i = 0; i < 24; i++)
      if (i < 16) do_read(i[3:2], i[1:0]);
      else do_read(2'($urandom_range(3)), 2'($urandom_range(3)));
    axi_wr(xrc_pkg::OFS_CTRL, 32'h220, r);
    repeat (12) @(posedge clk_sys);
    chk(drst_n, 2, "digital reset width");
    for (int v = 0; v < 16; v++) begin
      axi_wr(xrc_pkg::OFS_CLKCFG, 32'(v), r);
      @(posedge clk_sys);
      chk({24'h0, tx_wr_clk_sel}, v[1] ? 32'hAA : v[0] ? 32'h54 : 32'h0, "tx select");
      chk({24'h0, rx_rd_clk_sel}, v[3:2] == 2'h0 ? 32'h0 : v[3:2] == 2'h1 ? 32'h55 : 32'hAA, "rx select");
      axi_rd(xrc_pkg::OFS_CLKCFG, d, r);
      chk(d, 32'(v), "clkcfg readback");
    end
    report_and_stop;
  end
endmodule
